// ===== rtl/uart_modem_ctl.sv
// queue enable / receive flush bits, handshake control and handshake status
// assumes a strobed parallel register port on pins and a serial core beside it
`timescale 1ns/10ps
`include "uart_modem_consts.svh"

// Behaviour
// RULE1: receive flush bit empties receive error queue, resets counters, self clears.
// RULE2: queue enable bit 0 turns both queues off at 0, on at 1.
// RULE3: entering queue mode does not discard data already held.
// RULE4: a write changing the enable bit flushes error queue and clears counters.
// RULE5: flush bit writes ignored unless enable bit already 1.
// RULE6: queue mode only when enable and serial permit are both 1.
// RULE7: handshake control bits 7 to 5 always read as zero.
// RULE8: loopback holds serial out high, ignores serial in, wraps transmit into receive.
// RULE9: loopback replaces the four handshake inputs with control bits 3 to 0.
// RULE10: loopback maps dtr, rts, spare, irq bits onto status bits 5,4,6,7.
// RULE11: loopback and stand-alone float the interrupt-set output.
// RULE12: loopback keeps modem interrupts, sourced from control bits, gated by enable.
// RULE13: software restores registers before clearing the loopback bit.
// RULE14: control bit 3 floats the interrupt-set output at 0, enables it at 1.
// RULE15: rts and dtr pins driven inverted from control bits 1 and 0.
// RULE16: change flags set on input change, all cleared by a status read.
// RULE17: status bits 7 to 4 show inverted dcd, ring, dsr, cts levels.
// RULE18: software may write the four change flags to exercise the interrupt.
// RULE19: any change flag set raises modem interrupt when enabled.
// RULE20: ring flag set only when ring indication goes from on to off.
// RULE21: handshake pins synchronised, compared each cycle; set beats clear-on-read.
module uart_modem_ctl
  import uart_modem_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // register port pins
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire uart_modem_pkg::reg_addr_t addr_i,
  input wire uart_modem_pkg::reg8_t data_i,
  output uart_modem_pkg::reg8_t data_o,
  output logic data_oe_n_o,
  // mode inputs from neighbouring registers
  input wire logic serial_queue_permit_i,
  input wire logic msi_enable_i,
  input wire logic irq_set_i,
  // queue control towards the queue logic
  output logic queue_enable_o,
  output logic queue_mode_o,
  output logic rx_err_flush_o,
  output logic tx_cnt_clear_o,
  output logic rx_cnt_clear_o,
  // serial data path
  input wire logic serial_in_i,
  input wire logic tx_shift_i,
  output logic serial_out_o,
  output logic rx_shift_o,
  // handshake pins
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic dcd_n_i,
  input wire logic ring_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  // interrupt paths
  output logic irq_set_out_o,
  output logic irq_set_out_oe_n_o,
  output logic msi_o
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  localparam int PIN_W = 19;

  logic [PIN_W-1:0] pins_async;
  logic [PIN_W-1:0] pins_sync;
  logic cs_s;
  logic rd_s;
  logic wr_s;
  reg_addr_t addr_s;
  reg8_t data_s;
  logic serial_in_inv_s;
  logic serial_in_s;
  line4_t hs_live_s;

  // active-low pins inverted ahead of the flops, so the zero that reset
  // leaves in them reads as idle: no phantom access, edge or start bit
  assign pins_async = {~cs_n_i, ~rd_n_i, ~wr_n_i, addr_i, data_i, ~serial_in_i,
                       ~dcd_n_i, ~ring_n_i, ~dsr_n_i, ~cts_n_i};
  assign {cs_s, rd_s, wr_s, addr_s, data_s, serial_in_inv_s, hs_live_s} =
    pins_sync;
  assign serial_in_s = ~serial_in_inv_s;

  // see RULE21
  sync_stage #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .async_i(pins_async),
    .sync_o(pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // strobe decode: act once at the leading edge of each access

  access_t acc_q;
  access_t acc_d;
  logic rd_start;
  logic wr_start;

  always_comb begin
    acc_d = ACC_IDLE;
    if (cs_s && rd_s) begin
      acc_d = ACC_READ;
    end else if (cs_s && wr_s) begin
      acc_d = ACC_WRITE;
    end
  end

  assign rd_start = (acc_d == ACC_READ) && (acc_q != ACC_READ);
  assign wr_start = (acc_d == ACC_WRITE) && (acc_q != ACC_WRITE);

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      acc_q <= ACC_IDLE;
    end else begin
      acc_q <= acc_d;
    end
  end

  logic wr_qc;
  logic wr_hc;
  logic wr_hs;
  logic rd_hs;

  assign wr_qc = wr_start && (addr_s == `OFS_QUEUE_CTL);
  assign wr_hc = wr_start && (addr_s == `OFS_HS_CTL);
  assign wr_hs = wr_start && (addr_s == `OFS_HS_STAT);
  assign rd_hs = rd_start && (addr_s == `OFS_HS_STAT);

  ////////////////////////////////////////////////////////////////////////////
  // queue control

  logic queue_en_q;
  logic en_change;
  logic flush_req;

  // enable seen before this write decides whether the flush bit counts
  assign en_change = wr_qc && (data_s[`QC_ENABLE] != queue_en_q);
  assign flush_req = wr_qc && queue_en_q && data_s[`QC_RX_FLUSH]; // see RULE5

  // no data discard on entering queue mode, only flush and counters
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      queue_en_q <= 1'b0;
    end else if (wr_qc) begin
      queue_en_q <= data_s[`QC_ENABLE]; // see RULE2 see RULE3
    end
  end

  // flush bit is never stored, so it reads back as zero at once
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_err_flush_o <= 1'b0;
    end else begin
      rx_err_flush_o <= flush_req || en_change; // see RULE1 see RULE4
    end
  end

  // transmit counter clears only on an enable change here
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_cnt_clear_o <= 1'b0;
    end else begin
      tx_cnt_clear_o <= en_change; // see RULE4
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_cnt_clear_o <= 1'b0;
    end else begin
      rx_cnt_clear_o <= flush_req || en_change; // see RULE1 see RULE4
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      queue_enable_o <= 1'b0;
    end else begin
      queue_enable_o <= queue_en_q;
    end
  end

  // permit comes from the neighbouring mode register, same clock
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      queue_mode_o <= 1'b0;
    end else begin
      queue_mode_o <= queue_en_q && serial_queue_permit_i; // see RULE6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake control

  logic [`HC_LIVE_MSB:0] hc_q;
  logic loop_on;

  assign loop_on = hc_q[`HC_LOOP];

  // upper three bits have no storage at all
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hc_q <= `HC_RESET;
    end else if (wr_hc) begin
      hc_q <= data_s[`HC_LIVE_MSB:0]; // see RULE7
    end
  end

  // pins keep following the control bits in loopback
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rts_n_o <= 1'b1;
      dtr_n_o <= 1'b1;
    end else begin
      rts_n_o <= ~hc_q[`HC_RTS]; // see RULE15
      dtr_n_o <= ~hc_q[`HC_DTR]; // see RULE15
    end
  end

  // serial out parks at mark in loopback so the line stays idle
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      serial_out_o <= 1'b1;
    end else begin
      serial_out_o <= loop_on ? 1'b1 : tx_shift_i; // see RULE8
    end
  end

  // receive input wraps from transmit in loopback; one cycle of latency
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rx_shift_o <= 1'b1;
    end else begin
      rx_shift_o <= loop_on ? tx_shift_i : serial_in_s; // see RULE8
    end
  end

  // interrupt-set output floats unless enabled and not looped back
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_set_out_o <= 1'b0;
      irq_set_out_oe_n_o <= 1'b1;
    end else begin
      irq_set_out_o <= irq_set_i;
      irq_set_out_oe_n_o <= ~(hc_q[`HC_IRQ] && !loop_on); // see RULE11 see RULE14
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // handshake status

  line4_t live;
  line4_t live_q;
  line4_t chg_flags_q;
  line4_t events;

  // live order: cts, dsr, ring, dcd, active high (pins are active low)
  always_comb begin
    if (loop_on) begin
      live = {hc_q[`HC_IRQ], hc_q[`HC_SPARE], hc_q[`HC_DTR], hc_q[`HC_RTS]}; // see RULE9 see RULE10
    end else begin
      live = hs_live_s; // see RULE17
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      live_q <= `FLAGS_RESET;
    end else begin
      live_q <= live;
    end
  end

  // toggling the loop bit can itself look like a change; software expects that
  always_comb begin
    events = live ^ live_q; // see RULE21
    events[`HS_RING_TE] = live_q[`HS_RING_TE] && !live[`HS_RING_TE]; // see RULE20
  end

  // set wins over both the clearing read and a software write
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chg_flags_q <= `FLAGS_RESET;
    end else if (wr_hs) begin
      chg_flags_q <= data_s[`HS_DCD_CHG:`HS_CTS_CHG] | events; // see RULE18
    end else if (rd_hs) begin
      chg_flags_q <= events; // see RULE16 see RULE21
    end else begin
      chg_flags_q <= chg_flags_q | events; // see RULE16 see RULE12
    end
  end

  // one enable gates loopback and normal sources alike
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      msi_o <= 1'b0;
    end else begin
      msi_o <= msi_enable_i && (|chg_flags_q); // see RULE19 see RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data

  reg8_t rd_mux;

  // queue control is write-only, so it reads as zero like unmapped offsets
  always_comb begin
    rd_mux = `BYTE_ZERO;
    if (addr_s == `OFS_HS_CTL) begin
      rd_mux = {3'h0, hc_q}; // see RULE7
    end else if (addr_s == `OFS_HS_STAT) begin
      rd_mux = {live, chg_flags_q}; // see RULE17 see RULE10
    end
  end

  // data captured at the read's leading edge and held for the strobe
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o <= `BYTE_ZERO;
    end else if (rd_start) begin
      data_o <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_oe_n_o <= 1'b1;
    end else begin
      data_oe_n_o <= (acc_d != ACC_READ);
    end
  end

endmodule

// ===== rtl/uart_modem_consts.svh
// register offsets, field positions and reset values of the handshake block
// assumes inclusion by bare name from the block's design files
`ifndef UART_MODEM_CONSTS_SVH
`define UART_MODEM_CONSTS_SVH

// register offsets on the three address pins
`define OFS_QUEUE_CTL 3'h2
`define OFS_HS_CTL 3'h4
`define OFS_HS_STAT 3'h6

// queue control fields
`define QC_ENABLE 0
`define QC_RX_FLUSH 1

// handshake control fields
`define HC_DTR 0
`define HC_RTS 1
`define HC_SPARE 2
`define HC_IRQ 3
`define HC_LOOP 4
`define HC_LIVE_MSB 4

// handshake status fields
`define HS_CTS_CHG 0
`define HS_DSR_CHG 1
`define HS_RING_TE 2
`define HS_DCD_CHG 3
`define HS_CTS 4
`define HS_DSR 5
`define HS_RING 6
`define HS_DCD 7

// reset values
`define HC_RESET 5'h00
`define FLAGS_RESET 4'h0
`define BYTE_ZERO 8'h00
`define DEPTH_SYNC 2

`endif

// ===== rtl/uart_modem_pkg.sv
// types shared by the handshake and queue control block
// assumes the consts header supplies every number
package uart_modem_pkg;

  typedef logic [7:0] reg8_t;
  typedef logic [2:0] reg_addr_t;
  typedef logic [3:0] line4_t;

  // phase of the asynchronous strobe port
  typedef enum logic [1:0] {
    ACC_IDLE,
    ACC_READ,
    ACC_WRITE
  } access_t;

endpackage

// ===== rtl/sync_stage.sv
// two flip-flop synchroniser for a group of pin levels
// assumes the inputs are asynchronous to clk_sys_i
`timescale 1ns/10ps
module sync_stage #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  ////////////////////////////////////////////////////////////////////////////
  // first stage is read only by the second
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= '0;
      sync_o <= '0;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ===== tb/uart_modem_ctl_monitor.sv
// concurrent checks on the handshake and queue control ports
// assumes binding onto uart_modem_ctl, one clock domain
`timescale 1ns/10ps
module uart_modem_ctl_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // watched inputs
  input wire logic serial_queue_permit_i,
  input wire logic msi_enable_i,
  input wire logic irq_set_i,
  input wire logic tx_shift_i,
  // watched outputs
  input wire logic queue_enable_o,
  input wire logic queue_mode_o,
  input wire logic rx_err_flush_o,
  input wire logic tx_cnt_clear_o,
  input wire logic rx_cnt_clear_o,
  input wire logic serial_out_o,
  input wire logic irq_set_out_o,
  input wire logic irq_set_out_oe_n_o,
  input wire logic msi_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////
  property p_mode;
    queue_mode_o == (queue_enable_o && $past(serial_queue_permit_i));
  endproperty
  a_mode: assert property (p_mode) else $error("queue mode wrong");
  property p_grp; tx_cnt_clear_o |-> rx_err_flush_o && rx_cnt_clear_o; endproperty
  a_grp: assert property (p_grp) else $error("enable change pulses split");
  property p_pair; rx_err_flush_o == rx_cnt_clear_o; endproperty
  a_pair: assert property (p_pair) else $error("flush without count clear");
  property p_one; rx_err_flush_o |=> !rx_err_flush_o; endproperty
  a_one: assert property (p_one) else $error("flush not self clearing");
  property p_gate; rx_err_flush_o && !tx_cnt_clear_o |-> queue_enable_o; endproperty
  a_gate: assert property (p_gate) else $error("flush while disabled");
  property p_irq; irq_set_out_o == $past(irq_set_i); endproperty
  a_irq: assert property (p_irq) else $error("interrupt copy wrong");
  property p_oe; !irq_set_out_oe_n_o |-> serial_out_o == $past(tx_shift_i); endproperty
  a_oe: assert property (p_oe) else $error("interrupt driven in loopback");
  property p_so; !serial_out_o |-> !$past(tx_shift_i); endproperty
  a_so: assert property (p_so) else $error("serial out low wrongly");
  property p_msi; msi_o |-> $past(msi_enable_i); endproperty
  a_msi: assert property (p_msi) else $error("modem interrupt not gated");
  ////////////////////////////////////////
  c_en: cover property (tx_cnt_clear_o);
  c_fl: cover property (rx_err_flush_o && !tx_cnt_clear_o);
  c_msi: cover property (msi_o);
endmodule
bind uart_modem_ctl uart_modem_ctl_monitor u_uart_modem_ctl_monitor (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .serial_queue_permit_i(serial_queue_permit_i),
  .msi_enable_i(msi_enable_i), .irq_set_i(irq_set_i), .tx_shift_i(tx_shift_i),
  .queue_enable_o(queue_enable_o), .queue_mode_o(queue_mode_o), .msi_o(msi_o),
  .rx_err_flush_o(rx_err_flush_o), .tx_cnt_clear_o(tx_cnt_clear_o),
  .rx_cnt_clear_o(rx_cnt_clear_o), .serial_out_o(serial_out_o), .irq_set_out_o(irq_set_out_o),
  .irq_set_out_oe_n_o(irq_set_out_oe_n_o));

// ===== tb/modem_model.sv
// data set stand-in on the handshake lines
// assumes active-low rts and dtr from the block, carrier and ring from the bench
`timescale 1ns/10ps
module modem_model #(
  parameter int DLY = 3
) (
  // clock
  input wire logic clk_i,
  // from the block
  input wire logic rts_n_i,
  input wire logic dtr_n_i,
  // bench requests
  input wire logic carrier_i,
  input wire logic ring_i,
  // to the block
  output logic cts_n_o,
  output logic dsr_n_o,
  output logic dcd_n_o,
  output logic ring_n_o
);
  ////////////////////////////////////////
  // answer lag, so the block never sees an instant echo
  logic [DLY-1:0] cts_q = '1;
  logic [DLY-1:0] dsr_q = '1;
  always @(posedge clk_i) begin
    cts_q <= {cts_q[DLY-2:0], rts_n_i};
    dsr_q <= {dsr_q[DLY-2:0], dtr_n_i};
  end
  assign cts_n_o = cts_q[DLY-1];
  assign dsr_n_o = dsr_q[DLY-1];
  assign dcd_n_o = ~carrier_i;
  assign ring_n_o = ~ring_i;
endmodule

// ===== tb/tb_uart_modem_ctl_fifo_enable.sv
// self-checking bench for queue enable, handshake control and status
// assumes the strobe port contract and a lagging modem model
`timescale 1ns/10ps
module tb_uart_modem_ctl_fifo_enable;
  import uart_modem_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic permit = 1'b0, msi_en = 1'b0, irq_in = 1'b0, serial_in = 1'b1, txs = 1'b1;
  logic carrier = 1'b0, ring = 1'b0;
  logic oe_n, q_en, q_mode, fl, txc, rxc, serial_out, rxs, cts_n, dsr_n, dcd_n, ring_n;
  logic rts_n, dtr_n, iro, iro_oe_n, msi;
  reg_addr_t addr = 3'h0;
  reg8_t wdata = 8'h00, rdata, dout;
  int num_errors = 0, cmp_count = 0, n_fl = 0, n_tx = 0, n_rx = 0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (fl === 1'b1) n_fl <= n_fl + 1;
    if (txc === 1'b1) n_tx <= n_tx + 1;
    if (rxc === 1'b1) n_rx <= n_rx + 1;
  end
  uart_modem_ctl u_uart_modem_ctl (.clk_sys_i(clk), .arst_n_i(arst_n), .cs_n_i(cs_n),
    .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr), .data_i(wdata), .data_o(dout),
    .data_oe_n_o(oe_n), .serial_queue_permit_i(permit), .msi_enable_i(msi_en),
    .irq_set_i(irq_in), .queue_enable_o(q_en), .queue_mode_o(q_mode), .rx_err_flush_o(fl),
    .tx_cnt_clear_o(txc), .rx_cnt_clear_o(rxc), .serial_in_i(serial_in), .tx_shift_i(txs),
    .serial_out_o(serial_out), .rx_shift_o(rxs), .cts_n_i(cts_n), .dsr_n_i(dsr_n), .dcd_n_i(dcd_n),
    .ring_n_i(ring_n), .rts_n_o(rts_n), .dtr_n_o(dtr_n), .irq_set_out_o(iro),
    .irq_set_out_oe_n_o(iro_oe_n), .msi_o(msi));
  modem_model #(.DLY(3)) u_modem_model (.clk_i(clk), .rts_n_i(rts_n), .dtr_n_i(dtr_n),
    .carrier_i(carrier), .ring_i(ring), .cts_n_o(cts_n), .dsr_n_o(dsr_n), .dcd_n_o(dcd_n),
    .ring_n_o(ring_n));
  ////////////////////////////////////////
  task automatic chk(input reg8_t got, input reg8_t exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // strobes held 4 cycles, so the two-flop sync always catches them
  task automatic wr(input reg_addr_t a, input reg8_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    idle(4);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    wdata <= ~d;
    idle(4);
  endtask
  task automatic rd(input reg_addr_t a, output reg8_t q);
    int n;
    @(posedge clk);
    addr <= a;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    for (n = 0; n < 10 && oe_n !== 1'b0; n++) begin
      @(posedge clk);
      #1;
    end
    q = dout;
    if (n == 10) chk(8'h00, 8'hff);
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    idle(4);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    idle(5000);
    num_errors++;
    tally_and_finish();
  end
  ////////////////////////////////////////
  initial begin
    idle(8);
    arst_n <= 1'b1;
    msi_en <= 1'b1;
    idle(12);
    rd(3'h6, rdata);
    wr(3'h4, 8'he3);
    chk({6'h0, rts_n, dtr_n}, 8'h00);
    rd(3'h4, rdata);
    chk(rdata, 8'h03);
    idle(10);
    chk({7'h0, msi}, 8'h01);
    rd(3'h6, rdata);
    chk(rdata, 8'h33);
    rd(3'h6, rdata);
    chk(rdata, 8'h30);
    ring <= 1'b1;
    idle(10);
    rd(3'h6, rdata);
    chk(rdata, 8'h70);
    ring <= 1'b0;
    idle(10);
    rd(3'h6, rdata);
    chk(rdata, 8'h34);
    carrier <= 1'b1;
    idle(10);
    rd(3'h6, rdata);
    chk(rdata, 8'hb8);
    wr(3'h6, 8'h0f);
    rd(3'h6, rdata);
    chk(rdata, 8'hbf);
    // flush before enable must be dropped
    wr(3'h2, 8'h02);
    chk(8'(n_fl * 16 + n_tx), 8'h00);
    permit <= 1'b1;
    wr(3'h2, 8'h03);
    chk(8'(n_fl * 16 + n_tx), 8'h11);
    chk({6'h0, q_en, q_mode}, 8'h03);
    permit <= 1'b0;
    wr(3'h2, 8'h03);
    chk(8'(n_fl * 16 + n_tx), 8'h21);
    chk({6'h0, q_en, q_mode}, 8'h02);
    wr(3'h2, 8'h00);
    chk(8'(n_fl * 16 + n_tx), 8'h32);
    chk({6'h0, q_en, q_mode}, 8'h00);
    // loopback: pins ignored, control bits feed status
    wr(3'h4, 8'h1f);
    txs <= 1'b0;
    idle(3);
    chk({5'h0, iro_oe_n, serial_out, rxs}, 8'h06);
    carrier <= 1'b0;
    idle(10);
    rd(3'h6, rdata);
    chk(rdata, 8'hf0);
    wr(3'h4, 8'h1b);
    chk({7'h0, msi}, 8'h01);
    msi_en <= 1'b0;
    idle(2);
    chk({7'h0, msi}, 8'h00);
    msi_en <= 1'b1;
    rd(3'h6, rdata);
    chk(rdata, 8'hb4);
    txs <= 1'b1;
    wr(3'h4, 8'h0b);
    irq_in <= 1'b1;
    idle(3);
    chk({6'h0, iro_oe_n, iro}, 8'h01);
    txs <= 1'b0;
    idle(3);
    chk({6'h0, serial_out, rxs}, 8'h01);
    chk(8'(n_rx), 8'h03);
    tally_and_finish();
  end
endmodule
